// *** design/sac_pkg.sv ***
// Shared constants and carrier types for the converter controller.
// Assumes a 16-bit word-addressed host register port on one system clock.
package sac_pkg;

   // Word addresses of the five registers
   localparam logic [15:0] SAC_ADDR_CONTROL = 16'h7012;
   localparam logic [15:0] SAC_ADDR_RESULT = 16'h7014;
   localparam logic [15:0] SAC_ADDR_CLKDIV = 16'h7016;
   localparam logic [15:0] SAC_ADDR_REFPIN = 16'h7018;
   localparam logic [15:0] SAC_ADDR_PINOUT = 16'h701a;

   // Register widths and reset values
   localparam int SAC_DW = 16;
   localparam logic [15:0] SAC_CONTROL_RST = 16'h0000;
   localparam logic [15:0] SAC_CLKDIV_RST = 16'h0000;
   localparam logic [15:0] SAC_REFPIN_RST = 16'h0000;
   localparam logic [15:0] SAC_PINOUT_RST = 16'h0000;
   localparam logic [15:0] SAC_READ_NONE = 16'h0000;

   // Converter timing and geometry
   localparam int SAC_CONV_CYCLES = 32;
   localparam int SAC_RES_W = 10;
   localparam int SAC_NUM_INPUTS = 6;
   localparam int SAC_NUM_PINS = 4;

   // Field positions inside reference/pin and pin output registers
   localparam int SAC_PEN_EN_BIT = 0;
   localparam int SAC_PIN_EN_LSB = 0;
   localparam int SAC_PIN_LVL_LSB = 4;

   // Control register layout, msb first
   typedef struct packed {
      logic conversion_start_bit;
      logic [2:0] input_channel_select;
      logic long_sample_mode;
      logic one_shot_mode;
      logic [9:0] spare;
   } sac_control_t;

   // Result register layout, msb first
   typedef struct packed {
      logic conversion_in_progress;
      logic [2:0] channel;
      logic [1:0] spare;
      logic [9:0] conversion_result;
   } sac_result_t;

   // Sequencer states, Gray coded along idle -> convert -> done
   typedef enum logic [1:0] {
      SAC_IDLE = 2'b00,
      SAC_CONV = 2'b01,
      SAC_DONE = 2'b11
   } sac_state_t;

   // One-hot switch word for a channel number; 6 and 7 open all switches
   function automatic logic [5:0] sac_switches(input logic [2:0] ch);
      logic [5:0] w;
      w = 6'h00;
      if (ch < 3'h6) begin
         w[ch] = 1'b1;
      end
      return w;
   endfunction : sac_switches

endpackage : sac_pkg

// *** design/sac_sync.sv ***
// Two-stage synchroniser for a bus of levels.
// Assumes inputs come from pins or from the analog macro, not this clock.
`timescale 1ns/1ns
`default_nettype none
module sac_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // First stage is read only by the second stage
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : sac_sync
`default_nettype wire

// *** design/sac_clkdiv.sv ***
// Converter clock divider: one-cycle enable every div_value+1 clocks.
// Assumes div_value comes from a register on the same clock.
`timescale 1ns/1ns
`default_nettype none
module sac_clkdiv #(
   parameter int WIDTH = 16
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] div_value,
   output logic tick
);

   logic [WIDTH-1:0] count;
   wire logic wrap = (count >= div_value);

   // A shrinking divider wraps at once rather than running to overflow
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
         tick <= 1'b0;
      end else begin
         count <= wrap ? '0 : count + 1'b1;
         tick <= wrap;
      end
   end

endmodule : sac_clkdiv
`default_nettype wire

// *** design/sac_ctrl.sv ***
// Control logic of a 10-bit successive-approximation converter: host
// registers, conversion sequencer, pin outputs and touch detection.
// Assumes a single-cycle host port on clk_sys and an analog macro that
// settles its result within the 32 converter clocks of a conversion.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Each analog pin, once output-enabled, drives low or high per its level bit.
// - Software or debugger resets leave all registers and operation untouched.
// - Hardware reset returns every register to its default value.
// - No peripheral reset exists; only the hardware reset initialises state.
// - At sequence end hardware clears busy flag, and start bit in one-shot mode.
// - With busy low the result register holds data and its channel.
// - An interrupt is raised whenever a conversion result becomes readable.
// - A panel press raises an interrupt without running conversions.
// - Debug halts never stop or pause converter operation.
// - Five registers sit at consecutive even word addresses from 7012h.
// - Control: start 15, channel 14-12, long sample 11, one-shot 10.
// - All control fields are read/write and reset to zero.
// - Start bit 1 asserts the internal start signal; 0 starts nothing.
// - Channel values 0 to 5 route the input of that number.
// - Each conversion lasts 32 divided converter clocks.
// - Channel values 6 and 7 open every input switch.
// - One-shot converts once and stops; otherwise back-to-back while started.
// - A DMA request is issued at the end of every conversion.
module sac_ctrl
   import sac_pkg::*;
#(
   parameter int DIV_W = 16,
   parameter int CONV_CYCLES = SAC_CONV_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [15:0] host_addr,
   input wire logic [15:0] host_wdata,
   input wire logic host_wr,
   input wire logic host_rd,
   output logic [15:0] host_rdata,
   output logic conv_start,
   output logic [5:0] input_switches,
   output logic long_sample,
   output logic [15:0] ref_pin_setting,
   input wire logic [SAC_RES_W-1:0] analog_result,
   input wire logic [SAC_NUM_PINS-1:0] analog_io_pin_in,
   output logic [SAC_NUM_PINS-1:0] analog_io_pin_out,
   output logic [SAC_NUM_PINS-1:0] analog_io_pin_oe_n,
   input wire logic touch_sense_n,
   output logic conversion_done_irq,
   output logic touch_press_interrupt,
   output logic dma_request
);

   localparam int CNT_W = $clog2(CONV_CYCLES);
   localparam logic [CNT_W-1:0] LAST_CYCLE = CNT_W'(CONV_CYCLES - 1);

   // Host-visible registers
   sac_control_t converter_control;
   sac_result_t converter_result;
   logic [15:0] converter_clock_divider;
   logic [15:0] reference_and_pin_control;
   logic [15:0] pin_output_control;

   // Sequencer state
   sac_state_t state;
   sac_state_t next_state;
   logic [CNT_W-1:0] cycle_count;
   logic [2:0] active_channel;

   // Synchronised inputs
   logic [SAC_RES_W-1:0] result_sync;
   logic touch_sync_n;
   logic touch_prev_n;

   // Divider enable
   logic conv_tick;

   // Address decode
   wire logic hit_control = (host_addr == SAC_ADDR_CONTROL);
   wire logic hit_result = (host_addr == SAC_ADDR_RESULT);
   wire logic hit_clkdiv = (host_addr == SAC_ADDR_CLKDIV);
   wire logic hit_refpin = (host_addr == SAC_ADDR_REFPIN);
   wire logic hit_pinout = (host_addr == SAC_ADDR_PINOUT);

   wire logic wr_control = host_wr && hit_control;
   wire logic wr_clkdiv = host_wr && hit_clkdiv;
   wire logic wr_refpin = host_wr && hit_refpin;
   wire logic wr_pinout = host_wr && hit_pinout;

   // Write image of the control register, all fields writable
   wire sac_control_t control_wr_image = sac_control_t'(host_wdata);

   // Sequencer events
   wire logic start_req = converter_control.conversion_start_bit;
   wire logic last_tick = conv_tick && (cycle_count == LAST_CYCLE);
   wire logic in_done = (state == SAC_DONE);
   wire logic one_shot_end = in_done && converter_control.one_shot_mode;

   // Busy and switch words for the next cycle
   wire logic next_busy = (next_state == SAC_CONV);
   wire logic [2:0] next_channel = (state == SAC_IDLE || in_done)
      ? converter_control.input_channel_select : active_channel;
   wire logic [5:0] next_switches = sac_switches(next_channel);

   // Pen press: falling edge on the sense line while detection is enabled
   wire logic pen_enabled = reference_and_pin_control[SAC_PEN_EN_BIT];
   wire logic pen_edge = pen_enabled && touch_prev_n && !touch_sync_n;

   // Pin drive fields
   wire logic [SAC_NUM_PINS-1:0] pin_enable =
      pin_output_control[SAC_PIN_EN_LSB +: SAC_NUM_PINS];
   wire logic [SAC_NUM_PINS-1:0] pin_level =
      pin_output_control[SAC_PIN_LVL_LSB +: SAC_NUM_PINS];

   // Read multiplexer; unmapped words read as zero
   wire logic [15:0] read_word =
      hit_control ? 16'(converter_control) :
      hit_result ? 16'(converter_result) :
      hit_clkdiv ? converter_clock_divider :
      hit_refpin ? reference_and_pin_control :
      hit_pinout ? pin_output_control : SAC_READ_NONE;

   // Converter clock enable from the programmed divider
   sac_clkdiv #(
      .WIDTH(DIV_W)
   ) u_clkdiv (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .div_value(converter_clock_divider[DIV_W-1:0]),
      .tick(conv_tick)
   );

   // Analog result word and pin sensing come from another domain
   sac_sync #(
      .WIDTH(SAC_RES_W)
   ) u_sync_result (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .async_in(analog_result),
      .sync_out(result_sync)
   );

   sac_sync #(
      .WIDTH(1)
   ) u_sync_touch (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .async_in(touch_sense_n),
      .sync_out(touch_sync_n)
   );

   // Next state of the conversion sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         SAC_IDLE: begin
            if (start_req) begin
               next_state = SAC_CONV;
            end
         end
         SAC_CONV: begin
            if (last_tick) begin
               next_state = SAC_DONE;
            end
         end
         SAC_DONE: begin
            // Continuous mode restarts straight away while start stays set
            if (start_req && !converter_control.one_shot_mode) begin
               next_state = SAC_CONV;
            end else begin
               next_state = SAC_IDLE;
            end
         end
         default: begin
            next_state = SAC_IDLE;
         end
      endcase
   end

   // Sequencer registers. Only the hardware reset touches them; there is
   // no soft reset or debug halt input by design.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= SAC_IDLE;
         cycle_count <= '0;
         active_channel <= 3'h0;
      end else begin
         state <= next_state;
         active_channel <= next_channel;
         if (next_state != state) begin
            cycle_count <= '0;
         end else if (conv_tick && state == SAC_CONV) begin
            cycle_count <= cycle_count + 1'b1;
         end
      end
   end

   // Control register: a host write in the same cycle beats the
   // hardware clear, so a fresh start is never swallowed.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         converter_control <= sac_control_t'(SAC_CONTROL_RST);
      end else if (wr_control) begin
         converter_control <= control_wr_image;
      end else if (one_shot_end) begin
         converter_control.conversion_start_bit <= 1'b0;
      end
   end

   // Plain configuration registers; only hardware reset clears them
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         converter_clock_divider <= SAC_CLKDIV_RST;
         reference_and_pin_control <= SAC_REFPIN_RST;
         pin_output_control <= SAC_PINOUT_RST;
      end else begin
         if (wr_clkdiv) begin
            converter_clock_divider <= host_wdata;
         end
         if (wr_refpin) begin
            reference_and_pin_control <= host_wdata;
         end
         if (wr_pinout) begin
            pin_output_control <= host_wdata;
         end
      end
   end

   // Result register: busy follows the sequencer, data and channel are
   // captured together on the final converter clock.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         converter_result <= '0;
      end else begin
         converter_result.conversion_in_progress <= next_busy;
         converter_result.spare <= 2'b00;
         if (state == SAC_CONV && last_tick) begin
            converter_result.conversion_result <= result_sync;
            converter_result.channel <= active_channel;
         end
      end
   end

   // Event pulses, one cycle each; done interrupt and DMA request on the cycle busy falls
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         conversion_done_irq <= 1'b0;
         dma_request <= 1'b0;
         touch_press_interrupt <= 1'b0;
         touch_prev_n <= 1'b1;
      end else begin
         conversion_done_irq <= (state == SAC_CONV) && last_tick;
         dma_request <= (state == SAC_CONV) && last_tick;
         touch_press_interrupt <= pen_edge;
         touch_prev_n <= touch_sync_n;
      end
   end

   // Analog macro controls; switches open while idle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         conv_start <= 1'b0;
         input_switches <= 6'h00;
         long_sample <= 1'b0;
         ref_pin_setting <= SAC_REFPIN_RST;
      end else begin
         conv_start <= next_busy;
         input_switches <= next_busy ? next_switches : 6'h00;
         long_sample <= converter_control.long_sample_mode;
         ref_pin_setting <= reference_and_pin_control;
      end
   end

   // Pin outputs. Enable is active low on the pad; a disabled pin is
   // released to the analog path.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         analog_io_pin_out <= '0;
         analog_io_pin_oe_n <= '1;
      end else begin
         analog_io_pin_out <= pin_level;
         analog_io_pin_oe_n <= ~pin_enable;
      end
   end

   // Registered read data, valid the cycle after the read strobe.
   // Reads have no side effects; busy polling is safe at any rate.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         host_rdata <= SAC_READ_NONE;
      end else if (host_rd) begin
         host_rdata <= read_word;
      end
   end

   // The pin inputs are sensed by the analog macro only
   wire logic unused_pins = ^analog_io_pin_in;

endmodule : sac_ctrl
`default_nettype wire

// *** dv/sac_ctrl_chk.sv ***
// Port-level assertions for the converter controller.
// Bound into sac_ctrl; one clock domain with an async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module sac_ctrl_chk (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [15:0] host_addr,
   input wire logic [15:0] host_wdata,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [15:0] host_rdata,
   input wire logic conv_start,
   input wire logic [5:0] input_switches,
   input wire logic [15:0] ref_pin_setting,
   input wire logic [3:0] analog_io_pin_out,
   input wire logic [3:0] analog_io_pin_oe_n,
   input wire logic touch_sense_n,
   input wire logic conversion_done_irq,
   input wire logic touch_press_interrupt,
   input wire logic dma_request
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // Completion events: both pulses coincide with the busy fall
   dma_with_irq_a: assert property (conversion_done_irq == dma_request)
      else $error("dma request and done interrupt differ");
   irq_on_fall_a: assert property ($fell(conv_start) == conversion_done_irq)
      else $error("done interrupt not at end of conversion");
   irq_single_a: assert property (conversion_done_irq |=> !conversion_done_irq)
      else $error("done interrupt longer than one cycle");
   // Switches: at most one closed, none while idle
   switch_onehot_a: assert property ($onehot0(input_switches))
      else $error("more than one input switch closed");
   switch_idle_a: assert property (!conv_start |-> input_switches == 6'h00)
      else $error("input switch closed while idle");
   // Result reads carry the busy level seen at the read edge
   busy_read_a: assert property (host_rd && host_addr == 16'h7014 |=>
      host_rdata[15] == $past(conv_start)) else $error("busy bit wrong");
   unmapped_zero_a: assert property (host_rd && host_addr[15:4] != 12'h701
      |=> host_rdata == 16'h0000) else $error("unmapped read not zero");
   // Lone write to pin control reaches the pads two edges later
   pin_drive_a: assert property (host_wr && host_addr == 16'h701a ##1
      !(host_wr && host_addr == 16'h701a) |=>
      analog_io_pin_oe_n == ~$past(host_wdata[3:0], 2) &&
      analog_io_pin_out == $past(host_wdata[7:4], 2))
      else $error("pin drive does not follow register");
   // Press detection through the synchroniser, then a single pulse
   touch_irq_a: assert property ($fell(touch_sense_n) && ref_pin_setting[0]
      |-> ##[3:5] touch_press_interrupt) else $error("press not reported");
   touch_pulse_a: assert property (touch_press_interrupt |=>
      !touch_press_interrupt) else $error("press interrupt too long");

   cover property (conversion_done_irq);
   cover property (touch_press_interrupt);
   // Back-to-back: busy is low only in the cycle the done pulse shows
   cover property (conversion_done_irq && !conv_start ##1 conv_start);
endmodule : sac_ctrl_chk

bind sac_ctrl sac_ctrl_chk sac_ctrl_chk_inst (.clk_sys, .nrst, .host_addr,
   .host_wdata, .host_wr, .host_rd, .host_rdata, .conv_start,
   .input_switches, .ref_pin_setting, .analog_io_pin_out, .analog_io_pin_oe_n,
   .touch_sense_n, .conversion_done_irq, .touch_press_interrupt, .dma_request);
`default_nettype wire

// *** dv/sac_ctrl_tb.sv ***
// Self-checking bench for sac_ctrl against a register model.
// Drives every port itself; the analog macro is a held random word.
`timescale 1ns/1ns
`default_nettype none
module sac_ctrl_tb import sac_pkg::*; ;
   localparam int CC = 4;
   localparam int DIV = 12; // 25 MHz / 13 stays under the 2 MHz limit
   localparam int LO = (CC - 1) * (DIV + 1);
   localparam int HI = CC * (DIV + 1) + 1;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] host_addr = 16'h0000;
   logic [15:0] host_wdata = 16'h0000;
   logic host_wr = 1'b0;
   logic host_rd = 1'b0;
   logic [9:0] analog_result = 10'h000;
   logic touch_sense_n = 1'b1;
   logic [15:0] host_rdata, ref_pin_setting, v;
   logic conv_start, long_sample, conversion_done_irq;
   logic touch_press_interrupt, dma_request;
   logic [5:0] input_switches;
   logic [3:0] pin_out, pin_oe_n;
   logic [15:0] mdl [int];
   int fails = 0;
   int n_tests = 0;
   int n, k, j;

   always #20 clk_sys = ~clk_sys;

   sac_ctrl #(.CONV_CYCLES(CC)) sac_ctrl_inst (.clk_sys, .nrst, .host_addr,
      .host_wdata, .host_wr, .host_rd, .host_rdata, .conv_start,
      .input_switches, .long_sample, .ref_pin_setting, .analog_result,
      .analog_io_pin_in(4'h0), .analog_io_pin_out(pin_out),
      .analog_io_pin_oe_n(pin_oe_n), .touch_sense_n, .conversion_done_irq,
      .touch_press_interrupt, .dma_request);

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   // Writes to the result word are dropped, as the model mirrors
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      host_wr <= 1'b1;
      host_addr <= a;
      host_wdata <= d;
      @(posedge clk_sys);
      host_wr <= 1'b0;
      if (a != SAC_ADDR_RESULT && mdl.exists(a)) mdl[a] = d;
   endtask : wr

   task automatic rd(input logic [15:0] a);
      @(posedge clk_sys);
      host_rd <= 1'b1;
      host_addr <= a;
      @(posedge clk_sys);
      host_rd <= 1'b0;
      #1 chk("rdata", mdl.exists(a) ? mdl[a] : 16'h0000, host_rdata);
   endtask : rd

   task automatic do_reset();
      nrst <= 1'b0;
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      foreach (mdl[a]) mdl[a] = 16'h0000;
   endtask : do_reset

   // One-shot conversion; switches and length watched while busy
   task automatic conv(input logic [2:0] ch, input logic ls);
      logic [15:0] c;
      logic [9:0] r;
      c = {1'b1, ch, ls, 1'b1, 10'h000};
      r = 10'($urandom);
      analog_result <= r;
      wr(SAC_ADDR_CONTROL, c);
      n = 0;
      k = 0;
      v = 16'h0000;
      // Poll busy first, as software must; busy cycles seen meanwhile count
      while (v[15] !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         host_rd <= 1'b1;
         host_addr <= SAC_ADDR_RESULT;
         #1 if (conv_start === 1'b1) k++;
         @(posedge clk_sys);
         host_rd <= 1'b0;
         #1 v = host_rdata;
         if (conv_start === 1'b1) k++;
         n += 2;
      end
      chk("busy", 16'h0001, 16'(v[15]));
      while (conversion_done_irq !== 1'b1) begin
         @(posedge clk_sys);
         #1 n++;
         if (n > 300) begin
            fails++;
            report_and_stop();
         end
         if (conv_start === 1'b1) begin
            k++;
            chk("switches", (ch < 3'h6) ? 16'(1 << ch) : 16'h0000,
                16'(input_switches));
            chk("long_sample", 16'(ls), 16'(long_sample));
         end
      end
      chk("conv_len", 16'h0001, 16'(k >= LO && k <= HI));
      chk("dma", 16'h0001, 16'(dma_request));
      mdl[SAC_ADDR_RESULT] = {1'b0, ch, 2'b00, r};
      mdl[SAC_ADDR_CONTROL] = c & 16'h7fff;
      rd(SAC_ADDR_RESULT);
      rd(SAC_ADDR_CONTROL);
   endtask : conv

   // Main sequence: reset values, register access, conversions, pins, touch
   initial begin
      v = $urandom(32'h6271);
      for (j = 0; j < 5; j++) mdl[32'h7012 + 2 * j] = 16'h0000;
      do_reset();
      foreach (mdl[a]) rd(16'(a));
      chk("pin_oe_n", 16'h000f, 16'(pin_oe_n));
      for (j = 0; j < 3; j++) begin
         wr(SAC_ADDR_CONTROL, 16'($urandom) & 16'h7fff);
         rd(SAC_ADDR_CONTROL);
      end
      wr(SAC_ADDR_RESULT, 16'hffff);
      rd(SAC_ADDR_RESULT);
      rd(16'h7010);
      rd(16'h701c);
      wr(SAC_ADDR_CLKDIV, 16'(DIV));
      rd(SAC_ADDR_CLKDIV);
      wr(SAC_ADDR_REFPIN, 16'h0001);
      for (j = 0; j < 8; j++) conv(3'(j), j[0]);
      wr(SAC_ADDR_CONTROL, 16'h9000);
      k = 0;
      for (n = 0; n < 300 && k < 2; n++) begin
         @(posedge clk_sys);
         #1 if (conversion_done_irq === 1'b1) k++;
      end
      chk("back_to_back", 16'h0002, 16'(k));
      wr(SAC_ADDR_CONTROL, 16'h0000);
      repeat (80) @(posedge clk_sys);
      #1 chk("stopped", 16'h0000, 16'(conv_start));
      mdl[SAC_ADDR_RESULT] = {1'b0, 3'h1, 2'b00, analog_result};
      rd(SAC_ADDR_RESULT);
      for (j = 0; j < 3; j++) begin
         v = 16'($urandom) & 16'h00ff;
         wr(SAC_ADDR_PINOUT, v);
         repeat (2) @(posedge clk_sys);
         // Concatenation keeps the inversion at four bits
         #1 chk("pin_oe_n", {12'h000, ~v[3:0]}, 16'(pin_oe_n));
         chk("pin_out", 16'(v[7:4]), 16'(pin_out));
         rd(SAC_ADDR_PINOUT);
      end
      // Press with detection on, then off; each leaves the pin high again
      for (j = 1; j >= 0; j--) begin
         wr(SAC_ADDR_REFPIN, 16'(j));
         repeat (3) @(posedge clk_sys);
         #1 chk("ref_pin", 16'(j), ref_pin_setting);
         touch_sense_n <= 1'b0;
         k = 0;
         repeat (10) begin
            @(posedge clk_sys);
            #1 if (touch_press_interrupt === 1'b1) k++;
         end
         chk("touch_irq", 16'(j), 16'(k));
         @(posedge clk_sys);
         touch_sense_n <= 1'b1;
      end
      do_reset();
      foreach (mdl[a]) rd(16'(a));
      report_and_stop();
   end
endmodule : sac_ctrl_tb
`default_nettype wire
